/* File: hdl/aoic_offset_ctrl.sv */
/*
 * Accelerometer user-offset correction and interrupt-pin control.
 * Holds three signed offsets and a control register behind an Avalon-MM
 * slave, corrects each incoming sample for the output and wakeup paths,
 * and shapes the data-ready signal and both interrupt pins.
 * Assumes raw samples arrive synchronous to sys_clk with a valid strobe.
 */
// The implementer's own choice: the Avalon-MM register port.
// What this block does
// - subtract each axis offset (3Ch, 3Dh, 3Eh) from that axis's acceleration.
// - each offset is an 8-bit signed two's complement field.
// - weight bit picks 977 ug or 15.6 mg per offset step.
// - offset-on-output bit applies correction to output data registers.
// - offset-on-wakeup bit corrects only the wakeup detection data.
// - data-ready pulse bit: clear gives latched, set gives pulsed signalling.
// - route bit also drives second-pin signals onto the first pin.
// - high-pass reference mode bit enables that mode; clear by default.
// - orientation filter select: clear gives ODR/2 data, set gives second lowpass.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// one axis: scaled offset subtraction with saturation
// ------------------------------------------------------------
module aoic_axis_corr (
    input  wire logic signed [15:0] raw,
    input  wire logic        [7:0]  offset,
    input  wire logic               coarse,
    output logic signed      [15:0] corr,
    output logic                    sat
);
    logic signed [19:0] ofsScaled;
    logic signed [19:0] diff;

    // offset taken as signed and scaled by the selected weight
    always_comb begin
        if (coarse) begin
            ofsScaled = 20'(signed'(offset)) <<< aoic_pkg::OFS_COARSE_SHIFT;
        end else begin
            ofsScaled = 20'(signed'(offset)) <<< aoic_pkg::OFS_FINE_SHIFT;
        end
    end

    // subtract, then clamp so a large offset cannot wrap the sign
    always_comb begin
        diff = 20'(raw) - ofsScaled;
        sat  = 1'b0;
        corr = diff[15:0];
        if (diff > 20'sh07FFF) begin
            corr = 16'sh7FFF;
            sat  = 1'b1;
        end else if (diff < -20'sh08000) begin
            corr = -16'sh8000;
            sat  = 1'b1;
        end
    end
endmodule

// ------------------------------------------------------------
// top level
// ------------------------------------------------------------
module aoic_offset_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // avalon-mm slave, byte addressed
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // raw samples from the measurement chain
    input  wire logic        rawValid,
    input  wire logic [15:0] rawX,
    input  wire logic [15:0] rawY,
    input  wire logic [15:0] rawZ,
    // interrupt function levels routed to each pin
    input  wire logic        firstIrqFunc,
    input  wire logic        secondIrqFunc,
    // corrected output data
    output logic      [15:0] outX,
    output logic      [15:0] outY,
    output logic      [15:0] outZ,
    output logic             outValid,
    // data for the wakeup detection function
    output logic      [15:0] wakeX,
    output logic      [15:0] wakeY,
    output logic      [15:0] wakeZ,
    // filter configuration to the processing chain
    output logic             highpassReferenceMode,
    output logic             orientationFilterSelect,
    // pins and bus interrupt
    output logic             firstIrqPin,
    output logic             secondIrqPin,
    output logic             irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  ofsReg [3];
    logic [7:0]  ctrlReg;
    logic [2:0]  statusReg;
    logic [2:0]  statusNext;
    logic [2:0]  maskReg;
    logic        ackReg;
    logic [31:0] readdataReg;
    logic [15:0] outReg  [3];
    logic [15:0] wakeReg [3];
    logic        outValidReg;
    logic        rdyLatchReg;
    logic [7:0]  rdyCntReg;
    logic        firstPinReg;
    logic        secondPinReg;

    logic [5:0]  regIdx;
    logic        wrStb;
    logic        rdStb;
    logic        dataRead;
    logic [15:0] rawAxis [3];
    logic [15:0] corrAxis [3];
    logic [2:0]  satAxis;
    logic        outSat;
    logic        wuSat;
    logic        rdySignal;

    assign regIdx = avs_address[7:2];

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, then the access completes
    // ------------------------------------------------------------
    // every access stalls one cycle so read data can come from a flop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ackReg <= 1'b0;
        end else begin
            ackReg <= (avs_read | avs_write) & ~ackReg;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ackReg;
    assign wrStb           = avs_write & ackReg;
    assign rdStb           = avs_read & ackReg;
    // reading any output register counts as collecting the sample
    assign dataRead        = rdStb & ((regIdx == aoic_pkg::IDX_OUT_X) |
                                      (regIdx == aoic_pkg::IDX_OUT_Y) |
                                      (regIdx == aoic_pkg::IDX_OUT_Z));

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // offsets stored as written; range -127..127 is the host's duty
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ofsReg[0] <= aoic_pkg::OFS_RESET;
            ofsReg[1] <= aoic_pkg::OFS_RESET;
            ofsReg[2] <= aoic_pkg::OFS_RESET;
        end else if (wrStb) begin
            case (regIdx)
                aoic_pkg::IDX_X_OFS: ofsReg[0] <= avs_writedata[7:0];
                aoic_pkg::IDX_Y_OFS: ofsReg[1] <= avs_writedata[7:0];
                aoic_pkg::IDX_Z_OFS: ofsReg[2] <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // control register, all features off after reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrlReg <= aoic_pkg::CTRL_RESET;
        end else if (wrStb && regIdx == aoic_pkg::IDX_CTRL) begin
            ctrlReg <= avs_writedata[7:0];
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            maskReg <= aoic_pkg::STS_RESET;
        end else if (wrStb && regIdx == aoic_pkg::IDX_MASK) begin
            maskReg <= avs_writedata[2:0];
        end
    end

    // ------------------------------------------------------------
    // read data, unmapped words read as zero
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            readdataReg <= 32'h0000_0000;
        end else if (avs_read && !ackReg) begin
            case (regIdx)
                aoic_pkg::IDX_X_OFS:  readdataReg <= {24'h00_0000, ofsReg[0]};
                aoic_pkg::IDX_Y_OFS:  readdataReg <= {24'h00_0000, ofsReg[1]};
                aoic_pkg::IDX_Z_OFS:  readdataReg <= {24'h00_0000, ofsReg[2]};
                aoic_pkg::IDX_CTRL:   readdataReg <= {24'h00_0000, ctrlReg};
                aoic_pkg::IDX_OUT_X:  readdataReg <= {16'h0000, outReg[0]};
                aoic_pkg::IDX_OUT_Y:  readdataReg <= {16'h0000, outReg[1]};
                aoic_pkg::IDX_OUT_Z:  readdataReg <= {16'h0000, outReg[2]};
                aoic_pkg::IDX_STATUS: readdataReg <= {29'h0000_0000, statusReg};
                aoic_pkg::IDX_MASK:   readdataReg <= {29'h0000_0000, maskReg};
                default:              readdataReg <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata = readdataReg;

    // ------------------------------------------------------------
    // per-axis correction
    // ------------------------------------------------------------
    assign rawAxis[0] = rawX;
    assign rawAxis[1] = rawY;
    assign rawAxis[2] = rawZ;

    // one corrector per axis, shared by output and wakeup paths
    for (genvar a = 0; a < 3; a++) begin : gAxis
        aoic_axis_corr uCorr (
            .raw    (signed'(rawAxis[a])),
            .offset (ofsReg[a]),
            .coarse (ctrlReg[aoic_pkg::CTL_OFS_WEIGHT]),
            .corr   (corrAxis[a]),
            .sat    (satAxis[a])
        );
    end

    // output path gets the correction only when enabled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            outReg[0] <= 16'h0000;
            outReg[1] <= 16'h0000;
            outReg[2] <= 16'h0000;
        end else if (rawValid) begin
            for (int a = 0; a < 3; a++) begin
                if (ctrlReg[aoic_pkg::CTL_OFS_OUT]) begin
                    outReg[a] <= corrAxis[a];
                end else begin
                    outReg[a] <= rawAxis[a];
                end
            end
        end
    end

    // wakeup path corrected independently of the output bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wakeReg[0] <= 16'h0000;
            wakeReg[1] <= 16'h0000;
            wakeReg[2] <= 16'h0000;
        end else if (rawValid) begin
            for (int a = 0; a < 3; a++) begin
                if (ctrlReg[aoic_pkg::CTL_OFS_WU]) begin
                    wakeReg[a] <= corrAxis[a];
                end else begin
                    wakeReg[a] <= rawAxis[a];
                end
            end
        end
    end

    // new-sample strobe aligned with the output registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            outValidReg <= 1'b0;
        end else begin
            outValidReg <= rawValid;
        end
    end

    assign outX     = outReg[0];
    assign outY     = outReg[1];
    assign outZ     = outReg[2];
    assign wakeX    = wakeReg[0];
    assign wakeY    = wakeReg[1];
    assign wakeZ    = wakeReg[2];
    assign outValid = outValidReg;

    // filter settings go straight to the processing chain
    assign highpassReferenceMode   = ctrlReg[aoic_pkg::CTL_HP_REF];
    assign orientationFilterSelect = ctrlReg[aoic_pkg::CTL_ORIENT_LP2];

    // ------------------------------------------------------------
    // data-ready signalling
    // ------------------------------------------------------------
    // latched flag: a new sample in the read cycle wins over the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdyLatchReg <= 1'b0;
        end else if (rawValid) begin
            rdyLatchReg <= 1'b1;
        end else if (dataRead) begin
            rdyLatchReg <= 1'b0;
        end
    end

    // pulsed form: fixed width, restarted by every sample
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdyCntReg <= 8'h00;
        end else if (rawValid) begin
            rdyCntReg <= aoic_pkg::RDY_PULSE_LOAD;
        end else if (rdyCntReg != 8'h00) begin
            rdyCntReg <= rdyCntReg - 8'h01;
        end
    end

    // mode bit picks latched or pulsed
    assign rdySignal = ctrlReg[aoic_pkg::CTL_RDY_PULSE] ? (rdyCntReg != 8'h00)
                                                        : rdyLatchReg;

    // ------------------------------------------------------------
    // interrupt pins
    // ------------------------------------------------------------
    // registered so the pins never glitch on bus writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            firstPinReg  <= 1'b0;
            secondPinReg <= 1'b0;
        end else if (!ctrlReg[aoic_pkg::CTL_IRQ_EN]) begin
            firstPinReg  <= 1'b0;
            secondPinReg <= 1'b0;
        end else begin
            firstPinReg  <= rdySignal | firstIrqFunc |
                            (ctrlReg[aoic_pkg::CTL_ROUTE_2TO1] & secondIrqFunc);
            secondPinReg <= secondIrqFunc;
        end
    end

    assign firstIrqPin  = firstPinReg;
    assign secondIrqPin = secondPinReg;

    // ------------------------------------------------------------
    // bus interrupt: sticky status, write one to clear
    // ------------------------------------------------------------
    // saturation only counts on the path that actually uses the correction
    assign outSat = rawValid & ctrlReg[aoic_pkg::CTL_OFS_OUT] & (|satAxis);
    assign wuSat  = rawValid & ctrlReg[aoic_pkg::CTL_OFS_WU] & (|satAxis);

    // a set in the clearing cycle survives the clear
    always_comb begin
        statusNext = statusReg;
        if (wrStb && regIdx == aoic_pkg::IDX_STATUS) begin
            statusNext = statusReg & ~avs_writedata[2:0];
        end
        statusNext[aoic_pkg::STS_SAMPLE]  = statusNext[aoic_pkg::STS_SAMPLE] | rawValid;
        statusNext[aoic_pkg::STS_OUT_SAT] = statusNext[aoic_pkg::STS_OUT_SAT] | outSat;
        statusNext[aoic_pkg::STS_WU_SAT]  = statusNext[aoic_pkg::STS_WU_SAT] | wuSat;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            statusReg <= aoic_pkg::STS_RESET;
        end else begin
            statusReg <= statusNext;
        end
    end

    // level output while any unmasked bit is set
    assign irq = |(statusReg & maskReg);

endmodule

`default_nettype wire

/* File: hdl/aoic_pkg.sv */
/*
 * Constants for the accelerometer user-offset and interrupt-control block:
 * register indices, control bit positions, reset values and timing counts.
 * Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none

package aoic_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ     = 40_000_000;
    localparam int unsigned RDY_PULSE_NS   = 1000;
    // longest pulse time, rounded down, never below one cycle
    localparam int unsigned RDY_PULSE_CYC_RAW = (RDY_PULSE_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned RDY_PULSE_CYC = (RDY_PULSE_CYC_RAW < 1) ? 1 : RDY_PULSE_CYC_RAW;
    localparam logic [7:0]  RDY_PULSE_LOAD = 8'(RDY_PULSE_CYC);

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_X_OFS   = 6'h3C;
    localparam logic [5:0] IDX_Y_OFS   = 6'h3D;
    localparam logic [5:0] IDX_Z_OFS   = 6'h3E;
    localparam logic [5:0] IDX_CTRL    = 6'h3F;
    localparam logic [5:0] IDX_OUT_X   = 6'h30;
    localparam logic [5:0] IDX_OUT_Y   = 6'h31;
    localparam logic [5:0] IDX_OUT_Z   = 6'h32;
    localparam logic [5:0] IDX_STATUS  = 6'h33;
    localparam logic [5:0] IDX_MASK    = 6'h34;

    // ------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTL_RDY_PULSE  = 7;
    localparam int unsigned CTL_ROUTE_2TO1 = 6;
    localparam int unsigned CTL_IRQ_EN     = 5;
    localparam int unsigned CTL_OFS_OUT    = 4;
    localparam int unsigned CTL_OFS_WU     = 3;
    localparam int unsigned CTL_OFS_WEIGHT = 2;
    localparam int unsigned CTL_HP_REF     = 1;
    localparam int unsigned CTL_ORIENT_LP2 = 0;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  OFS_RESET      = 8'h00;

    // ------------------------------------------------------------
    // offset weights: output data step taken as the fine weight
    // ------------------------------------------------------------
    localparam int unsigned OFS_FINE_UG    = 977;
    localparam int unsigned OFS_COARSE_UG  = 15600;
    localparam int unsigned OFS_FINE_SHIFT = 0;
    // coarse step is sixteen fine steps (15.6 mg / 977 ug)
    localparam int unsigned OFS_COARSE_SHIFT = 4;

    // ------------------------------------------------------------
    // interrupt status bits (write one to clear), mask same layout
    // ------------------------------------------------------------
    localparam int unsigned STS_SAMPLE  = 0;
    localparam int unsigned STS_OUT_SAT = 1;
    localparam int unsigned STS_WU_SAT  = 2;
    localparam int unsigned STS_WIDTH   = 3;
    localparam logic [2:0]  STS_RESET   = 3'h0;

endpackage

`default_nettype wire

/* File: verification/aoic_offset_ctrl_assertions.sv */
/* checker on the offset block's ports: sample path, config outputs, pins.
   assumes control and X offset change only by completed bus writes. */
`timescale 1ns/100ps
`default_nettype none
module aoic_offset_ctrl_assertions (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        rawValid,
    input wire logic [15:0] rawX,
    input wire logic        secondIrqFunc,
    input wire logic [15:0] outX,
    input wire logic        outValid,
    input wire logic [15:0] wakeX,
    input wire logic        highpassReferenceMode,
    input wire logic        orientationFilterSelect,
    input wire logic        firstIrqPin,
    input wire logic        secondIrqPin
);
    logic [7:0]         ctl_reg;
    logic [7:0]         ofsX_reg;
    logic signed [17:0] diffX;
    logic [15:0]        expX;
    // shadows follow the bus at the completing edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_reg <= 8'h00;
            ofsX_reg <= 8'h00;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address[7:2] == aoic_pkg::IDX_CTRL) ctl_reg <= avs_writedata[7:0];
            if (avs_address[7:2] == aoic_pkg::IDX_X_OFS) ofsX_reg <= avs_writedata[7:0];
        end
    end
    // expected X, 18 bits so the coarse step cannot wrap
    always_comb begin
        diffX = 18'(signed'(rawX)) - (18'(signed'(ofsX_reg)) <<< (ctl_reg[2] ? 4 : 0));
        if (diffX > 18'sh07FFF) expX = 16'h7FFF;
        else if (diffX < 18'sh38000) expX = 16'h8000;
        else expX = diffX[15:0];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    out_corr_a: assert property (rawValid && ctl_reg[4] |=> outValid && outX == $past(expX))
        else $error("output X not corrected by offset");
    out_raw_a: assert property (rawValid && !ctl_reg[4] |=> outX == $past(rawX))
        else $error("output X changed while correction off");
    wake_corr_a: assert property (rawValid && ctl_reg[3] |=> wakeX == $past(expX))
        else $error("wakeup X not corrected");
    wake_raw_a: assert property (rawValid && !ctl_reg[3] |=> wakeX == $past(rawX))
        else $error("wakeup X changed while correction off");
    cfg_out_a: assert property ({highpassReferenceMode, orientationFilterSelect} == ctl_reg[1:0])
        else $error("filter config outputs differ from control");
    irq_gate_a: assert property (!$past(ctl_reg[5]) |-> !firstIrqPin && !secondIrqPin)
        else $error("pin high with interrupts disabled");
    second_pin_a: assert property ($past(ctl_reg[5]) |-> secondIrqPin == $past(secondIrqFunc))
        else $error("second pin does not follow its function");
    route_a: assert property ($past(ctl_reg[5] && ctl_reg[6] && secondIrqFunc) |-> firstIrqPin)
        else $error("second pin signal not routed to first pin");
    pulse_hold_a: assert property (rawValid && ctl_reg[7] && ctl_reg[5] |-> ##2 firstIrqPin [*8] ##32 firstIrqPin)
        else $error("data ready pulse too short");
    pulse_c: cover property (rawValid && ctl_reg[7] && ctl_reg[5]);
    route_c: cover property (firstIrqPin && ctl_reg[6] && secondIrqFunc);
    coarse_c: cover property (rawValid && ctl_reg[4] && ctl_reg[2]);
endmodule
bind aoic_offset_ctrl aoic_offset_ctrl_assertions aoic_offset_ctrl_assertions_i (
    .sys_clk, .rst, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest, .rawValid,
    .rawX, .secondIrqFunc, .outX, .outValid, .wakeX, .highpassReferenceMode,
    .orientationFilterSelect, .firstIrqPin, .secondIrqPin);
`default_nettype wire

/* File: verification/aoic_host_model.sv */
/* host model: a plain Avalon-MM master for the register bus.
   assumes one clock and that waitrequest ends every request. */
`timescale 1ns/100ps
`default_nettype none
module aoic_host_model (
    input wire logic        sys_clk,
    input wire logic        avs_waitrequest,
    output logic     [7:0]  avs_address,
    output logic            avs_read,
    output logic            avs_write,
    output logic     [31:0] avs_writedata
);
    // low-pass filter path select value; no task in this model drives it onto the bus
    localparam logic FILTER_PATH_SELECT = 1'b0;
    // idle bus from time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
    end
    // hold the request until waitrequest is seen low at a rising edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest);
        // released lines show the inverse, never a stale copy
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~addr;
        avs_writedata <= ~data;
    endtask
endmodule
`default_nettype wire

/* File: verification/aoic_offset_ctrl_test.sv */
/* self-checking bench for the offset and interrupt-control block.
   assumes the host model for bus cycles and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module aoic_offset_ctrl_test;
    logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest, rawValid, outValid;
    logic        firstIrqFunc, secondIrqFunc, firstIrqPin, secondIrqPin, irq;
    logic        highpassReferenceMode, orientationFilterSelect;
    logic [7:0]  avs_address, ctl, ofs [3];
    logic [31:0] avs_writedata, avs_readdata, seed, expRd [$];
    logic [15:0] rawX, rawY, rawZ, outX, outY, outZ, wakeX, wakeY, wakeZ, lastX;
    logic [95:0] expOut [$];
    int          n_errors, total_checks, n;
    aoic_offset_ctrl aoic_offset_ctrl_i (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .rawValid, .rawX, .rawY, .rawZ,
        .firstIrqFunc, .secondIrqFunc, .outX, .outY, .outZ, .outValid, .wakeX, .wakeY, .wakeZ,
        .highpassReferenceMode, .orientationFilterSelect, .firstIrqPin, .secondIrqPin, .irq);
    aoic_host_model aoic_host_model_i (.sys_clk, .avs_waitrequest, .avs_address, .avs_read,
        .avs_write, .avs_writedata);
    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // raw kept small so random offsets never clamp
    function automatic logic [15:0] sx(input logic [31:0] r);
        return {{3{r[12]}}, r[12:0]};
    endfunction
    function automatic logic [15:0] corr(input logic [15:0] raw, input logic [7:0] o);
        int v;
        v = $signed(raw) - $signed(o) * (ctl[2] ? 16 : 1);
        if (v > 32767) return 16'h7FFF;
        if (v < -32768) return 16'h8000;
        return v[15:0];
    endfunction
    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        aoic_host_model_i.access(1'b1, a, {24'h000000, d});
        if (a == 8'hFC) ctl = d;
        if (a >= 8'hF0 && a <= 8'hF8) ofs[(a - 8'hF0) >> 2] = d;
    endtask
    task automatic rdReg(input logic [7:0] a, input logic [31:0] e);
        expRd.push_back(e);
        aoic_host_model_i.access(1'b0, a, 32'h00000000);
    endtask
    task automatic sample(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        logic [47:0] c;
        c = {corr(x, ofs[0]), corr(y, ofs[1]), corr(z, ofs[2])};
        expOut.push_back({ctl[4] ? c : {x, y, z}, ctl[3] ? c : {x, y, z}});
        lastX = ctl[4] ? c[47:32] : x;
        @(posedge sys_clk);
        rawValid <= 1'b1;
        rawX <= x;
        rawY <= y;
        rawZ <= z;
        @(posedge sys_clk);
        rawValid <= 1'b0;
    endtask
    // pins and irq as {first, second, irq}, looked at mid-cycle
    task automatic pins(input int w, input logic [2:0] e);
        repeat (w) @(posedge sys_clk);
        @(negedge sys_clk);
        check("pins", 96'(e), 96'({firstIrqPin, secondIrqPin, irq}));
    endtask
    // results are taken off the queues as they appear
    always @(posedge sys_clk) begin
        if (outValid === 1'b1) begin
            if (expOut.size() == 0) check("outValid", 96'h0, 96'h1);
            else check("sample", expOut.pop_front(), {outX, outY, outZ, wakeX, wakeY, wakeZ});
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expRd.size() > 0)
            check("readdata", 96'(expRd.pop_front()), 96'(avs_readdata));
    end
    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles of the run
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("unexpected run length expected done seen timeout");
        results();
    end
    initial begin
        {rst, rawValid, firstIrqFunc, secondIrqFunc} = 4'h8;
        {rawX, rawY, rawZ} = 48'h0;
        {n_errors, total_checks, seed, ctl, ofs[0], ofs[1], ofs[2]} = {64'h0, 32'h5191, 32'h0};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        // reset values, then an unmapped place
        for (int i = 0; i < 4; i++) rdReg(8'hF0 + 8'(4 * i), 32'h00000000);
        rdReg(8'h40, 32'h00000000);
        // every path and weight mix, with all four config bit pairs
        for (int m = 0; m < 8; m++) begin
            for (int a = 0; a < 3; a++) wrReg(8'hF0 + 8'(4 * a), 8'(rnd() % 255) - 8'h7F);
            wrReg(8'hFC, {3'b000, 3'(m), 2'(m)});
            rdReg(8'hF0, {24'h000000, ofs[0]});
            pins(0, 3'b000);
            check("cfg", 96'(ctl[1:0]), 96'({highpassReferenceMode, orientationFilterSelect}));
            for (int s = 0; s < 3; s++) sample(sx(rnd()), sx(rnd()), sx(rnd()));
        end
        // clamping at both ends with the coarse weight
        wrReg(8'hF0, 8'h7F);
        wrReg(8'hF4, 8'h81);
        wrReg(8'hFC, 8'h1C);
        sample(16'h8000, 16'h7FFF, 16'h0000);
        rdReg(8'hC0, {16'h0000, lastX});
        // sticky status, mask, write-one-to-clear
        pins(1, 3'b000);
        rdReg(8'hCC, 32'h00000007);
        wrReg(8'hD0, 8'h01);
        pins(1, 3'b001);
        wrReg(8'hCC, 8'h07);
        pins(1, 3'b000);
        wrReg(8'hD0, 8'h00);
        // latched data ready holds until output data is read
        wrReg(8'hFC, 8'h20);
        pins(2, 3'b000);
        sample(sx(rnd()), sx(rnd()), sx(rnd()));
        pins(50, 3'b100);
        rdReg(8'hC0, {16'h0000, lastX});
        pins(2, 3'b000);
        // pulsed data ready, counted in cycles
        wrReg(8'hFC, 8'hA0);
        sample(sx(rnd()), sx(rnd()), sx(rnd()));
        n = 0;
        repeat (60) begin
            @(negedge sys_clk);
            if (firstIrqPin === 1'b1) n++;
        end
        check("pulse cycles", 96'(aoic_pkg::RDY_PULSE_CYC), 96'(n));
        rdReg(8'hC0, {16'h0000, lastX});
        // routing and global enable
        @(posedge sys_clk);
        secondIrqFunc <= 1'b1;
        pins(2, 3'b010);
        wrReg(8'hFC, 8'hE0);
        pins(2, 3'b110);
        wrReg(8'hFC, 8'hC0);
        pins(2, 3'b000);
        @(posedge sys_clk);
        {firstIrqFunc, secondIrqFunc} <= 2'b10;
        wrReg(8'hFC, 8'h20);
        pins(2, 3'b100);
        check("leftover samples", 96'h0, 96'(expOut.size()));
        results();
    end
endmodule
`default_nettype wire
